// ### design/sop_logic.sv
// registered sum-of-products logic element, all variants selected by parameter
// ------------------------------------------------------------------
// Summary of operation
// - 64 programmable AND terms feed 8 fixed OR gates, one per output.
// - each register is a D flip-flop loading its OR result on rising clock.
// - registered variants give 8, 6 or 4 registers; remaining outputs combinational.
// - one external active-low enable drives all registered output buffers together.
// - each combinational or bidir output enabled by its own product term.
// - register values feed back into the array regardless of output enable.
// - after power-on and a fixed delay every flip-flop clears Low.
// - preload loads each register from the level on its output pin.
// - registered variants: 8 dedicated inputs; combinational pins usable as inputs.
// - combinational variant: no registers, 10 inputs, 8 outputs, 6 bidirectional.
// - unprogrammed array has every link intact; opening links defines function.
// - blowing the security fuse blocks read-back of the pattern until rst_in clears the fuse.
// ------------------------------------------------------------------
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "sop_regs.svh"

module sop_logic #(
  parameter logic [1:0] VARIANT   = `SOP_VAR_R8,
  parameter int         PWRUP_CYC = `SOP_PWRUP_CYC
) (
  input  wire logic                                         sys_clk_in,
  input  wire logic                                         rst_in,
  input  wire logic [`SOP_NUM_DED_IN-1:0]                   ded_in,
  input  wire logic                                         oe_n_in,
  input  wire logic                                         preload_in,
  input  wire logic [`SOP_NUM_OUTS-1:0]                     pin_in,
  input  wire logic                                         prog_we_in,
  input  wire logic [5:0]                                   prog_term_in,
  input  wire logic [`SOP_ARRAY_COLS-1:0]                   prog_open_in,
  input  wire logic                                         fuse_blow_in,
  input  wire logic                                         rd_in,
  input  wire logic [5:0]                                   rd_term_in,
  output logic      [`SOP_ARRAY_COLS-1:0]                   rd_data_out,
  output logic      [`SOP_NUM_OUTS-1:0]                     pin_out,
  output logic      [`SOP_NUM_OUTS-1:0]                     pin_oe_out,
  output logic                                              ready_out
);
  import sop_pkg::*;

  // ------------------------------------------------------------------
  // variant decode: which output positions are registered
  // ------------------------------------------------------------------
  function automatic logic [`SOP_NUM_OUTS-1:0] reg_mask(input logic [1:0] v);
    case (v)
      `SOP_VAR_R8: reg_mask = 8'hFF;
      `SOP_VAR_R6: reg_mask = 8'h7E;
      `SOP_VAR_R4: reg_mask = 8'h3C;
      default:     reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  localparam logic [`SOP_NUM_OUTS-1:0] REG_MASK = reg_mask(VARIANT);
  // combinational variant: outer two outputs are output-only, so only the middle six reach the array

  // ------------------------------------------------------------------
  // fuse array: link intact = 0 in open_ff, so virgin state is all intact
  // ------------------------------------------------------------------
  logic [`SOP_ARRAY_COLS-1:0] open_ff [`SOP_NUM_TERMS];
  logic [`SOP_ARRAY_COLS-1:0] nxt_open [`SOP_NUM_TERMS];
  logic                       secure_ff, nxt_secure;
  logic [`SOP_ARRAY_COLS-1:0] nxt_rd_data;

  // programming only opens links; nothing closes them again
  always_comb begin
    for (int t = 0; t < `SOP_NUM_TERMS; t++) begin
      nxt_open[t] = open_ff[t];
    end
    if (prog_we_in) begin
      nxt_open[prog_term_in] = open_ff[prog_term_in] | prog_open_in;
    end
    nxt_secure  = secure_ff | fuse_blow_in;
    // read-back blanked once secured, also in the cycle the fuse blows
    nxt_rd_data = '0;
    if (rd_in && !secure_ff && !fuse_blow_in) begin
      nxt_rd_data = open_ff[rd_term_in];
    end
  end

  // pattern is non-volatile: the power-up reset leaves it alone
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      secure_ff   <= 1'b0;
      rd_data_out <= '0;
    end else begin
      secure_ff   <= nxt_secure;
      rd_data_out <= nxt_rd_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    for (int t = 0; t < `SOP_NUM_TERMS; t++) begin
      open_ff[t] <= nxt_open[t];
    end
  end

  initial begin
    for (int t = 0; t < `SOP_NUM_TERMS; t++) begin
      open_ff[t] = '0;
    end
  end

  // ------------------------------------------------------------------
  // power-up sequencer and output registers
  // ------------------------------------------------------------------
  sop_state_t             state_ff, nxt_state;
  logic [`SOP_CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [`SOP_NUM_OUTS-1:0] q_ff, nxt_q;
  logic [`SOP_NUM_OUTS-1:0] comb_ff, nxt_comb;
  logic [`SOP_NUM_OUTS-1:0] oe_ff, nxt_oe;
  logic                   nxt_ready;
  logic [`SOP_ARRAY_COLS-1:0] lits;
  logic [`SOP_NUM_TERMS-1:0]  pterm;
  logic [`SOP_NUM_OUTS-1:0]   or_sum, term_oe;
  logic [`SOP_ARRAY_IN-1:0]   arr_in;

  // array inputs: dedicated pins, then per position the register or the pin
  always_comb begin
    arr_in = '0;
    if (VARIANT == `SOP_VAR_COMB) begin
      arr_in = {ded_in[9:8], pin_in[6:1], ded_in[7:0]};
    end else begin
      arr_in[7:0] = ded_in[7:0];
      for (int i = 0; i < `SOP_NUM_OUTS; i++) begin
        // register feedback ignores the pin enable, so state machines work tri-stated
        arr_in[8+i] = REG_MASK[i] ? q_ff[i] : pin_in[i];
      end
    end
    lits = '0;
    for (int i = 0; i < `SOP_ARRAY_IN; i++) begin
      lits[2*i]   = arr_in[i];
      lits[2*i+1] = ~arr_in[i];
    end
  end

  // an intact link forces its literal into the AND; term with all links gives 0
  always_comb begin
    for (int t = 0; t < `SOP_NUM_TERMS; t++) begin
      pterm[t] = &(lits | open_ff[t]);
    end
    for (int o = 0; o < `SOP_NUM_OUTS; o++) begin
      // term 0 of each group of eight is the enable term on combinational outputs
      term_oe[o] = pterm[o*`SOP_TERMS_PER_OUT];
      or_sum[o]  = REG_MASK[o] ? |pterm[o*`SOP_TERMS_PER_OUT +: 8]
                               : |pterm[o*`SOP_TERMS_PER_OUT+1 +: 7];
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_q     = q_ff;
    nxt_comb  = or_sum;
    nxt_oe    = '0;
    nxt_ready = 1'b0;
    case (state_ff)
      SOP_ST_PWRUP: begin
        nxt_q = '0;
        if (cnt_ff == PWRUP_CYC[`SOP_CNT_W-1:0] - 8'h01) begin
          nxt_state = SOP_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      SOP_ST_RUN: begin
        nxt_ready = 1'b1;
        if (preload_in) begin
          nxt_q = pin_in & REG_MASK;
        end else begin
          nxt_q = or_sum & REG_MASK;
        end
        for (int o = 0; o < `SOP_NUM_OUTS; o++) begin
          if (REG_MASK[o]) begin
            nxt_oe[o] = ~oe_n_in;
          end else begin
            // every non-registered position is gated by its own enable term
            nxt_oe[o] = term_oe[o];
          end
        end
      end
      default: begin
        nxt_state = SOP_ST_PWRUP;
      end
    endcase
  end

  // outputs registered for timing; all pins stay tri-stated until power-up ends
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff  <= SOP_ST_PWRUP;
      cnt_ff    <= '0;
      q_ff      <= '0;
      comb_ff   <= '0;
      oe_ff     <= '0;
      ready_out <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      q_ff      <= nxt_q;
      comb_ff   <= nxt_comb;
      oe_ff     <= nxt_oe;
      ready_out <= nxt_ready;
    end
  end

  // pin data and enables come straight from flops, loaded from the same next values
  // as q_ff and oe_ff, so the pins never see a glitch from the output mux
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_out    <= '0;
      pin_oe_out <= '0;
    end else begin
      pin_out    <= (nxt_q & REG_MASK) | (nxt_comb & ~REG_MASK);
      pin_oe_out <= nxt_oe;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // power-up sequencing: registers low and pins released until ready
  chk_pwrup_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_PWRUP) |-> ##1 (q_ff == '0))
    else $error("register not cleared at power-up");
  chk_pwrup_tristate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !ready_out |-> (pin_oe_out == '0))
    else $error("pin driven before ready");
  chk_pwrup_q_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !ready_out |-> (q_ff == '0))
    else $error("register nonzero before ready");
  chk_pwrup_oe_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !ready_out |-> (oe_ff == '0))
    else $error("enable set before ready");
  chk_pwrup_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_PWRUP) |-> (cnt_ff < PWRUP_CYC[`SOP_CNT_W-1:0]))
    else $error("power-up counter overran");
  chk_run_stays: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN) |=> (state_ff == SOP_ST_RUN))
    else $error("left run state without reset");
  chk_run_cnt_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN) |=> $stable(cnt_ff))
    else $error("counter moved in run state");
  chk_ready_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ready_out |=> ready_out)
    else $error("ready dropped without reset");
  // register capture, preload and feedback
  chk_reg_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN && !preload_in) |=> (q_ff == ($past(or_sum) & REG_MASK)))
    else $error("register missed or result");
  chk_preload_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN && preload_in) |=> (q_ff == ($past(pin_in) & REG_MASK)))
    else $error("preload not loaded");
  chk_feedback_path: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (VARIANT != `SOP_VAR_COMB) |-> ((arr_in[15:8] & REG_MASK) == (q_ff & REG_MASK)))
    else $error("feedback not from register");
  chk_no_comb_regs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (VARIANT == `SOP_VAR_COMB) |-> (q_ff == '0))
    else $error("register in comb variant");
  chk_comb_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN) |=> ((comb_ff & ~REG_MASK) == ($past(or_sum) & ~REG_MASK)))
    else $error("combinational output wrong");
  chk_pin_data_reg: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pin_out == ((q_ff & REG_MASK) | (comb_ff & ~REG_MASK)))
    else $error("pin data differs from register");
  // output enables: one pin for registered outputs, a term for the rest
  chk_reg_enable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN) |=> ((oe_ff & REG_MASK) == ({8{~$past(oe_n_in)}} & REG_MASK)))
    else $error("registered enable wrong");
  chk_term_enable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == SOP_ST_RUN) |=> ((oe_ff & ~REG_MASK) == ($past(term_oe) & ~REG_MASK)))
    else $error("term enable wrong");
  chk_pin_oe_reg: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pin_oe_out == oe_ff)
    else $error("pin enable differs from register");
  // array links, read-back and security fuse
  chk_virgin_term: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (open_ff[0] == '0) |-> !pterm[0])
    else $error("intact term not low");
  chk_open_term: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (open_ff[0] == '1) |-> pterm[0])
    else $error("fully open term not high");
  chk_link_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    prog_we_in |=> ((open_ff[$past(prog_term_in)] & $past(prog_open_in)) == $past(prog_open_in)))
    else $error("link not opened");
  chk_rd_returns: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (rd_in && !secure_ff && !fuse_blow_in) |=> (rd_data_out == $past(open_ff[rd_term_in])))
    else $error("read-back wrong");
  chk_rd_idle_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rd_in |=> (rd_data_out == '0))
    else $error("read data without read");
  chk_secure_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (secure_ff || fuse_blow_in) |=> (rd_data_out == '0))
    else $error("pattern readable after fuse");
  chk_secure_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    secure_ff |=> secure_ff)
    else $error("security fuse cleared");
endmodule : sop_logic

// ### design/sop_regs.svh
// constants for the registered sum-of-products logic element
`ifndef SOP_REGS_SVH
`define SOP_REGS_SVH
// ------------------------------------------------------------------
// array geometry
// ------------------------------------------------------------------
`define SOP_NUM_TERMS      64
`define SOP_NUM_OUTS       8
`define SOP_TERMS_PER_OUT  8
`define SOP_NUM_DED_IN     10
`define SOP_ARRAY_IN       16
`define SOP_ARRAY_COLS     32
// ------------------------------------------------------------------
// variants and power-up timing
// ------------------------------------------------------------------
`define SOP_VAR_COMB       2'h0
`define SOP_VAR_R8         2'h1
`define SOP_VAR_R6         2'h2
`define SOP_VAR_R4         2'h3
`define SOP_PWRUP_NS       1000
`define SOP_CLK_NS         8
`define SOP_PWRUP_CYC      ((`SOP_PWRUP_NS + `SOP_CLK_NS - 1) / `SOP_CLK_NS)
`define SOP_CNT_W          8
`endif

// ### design/sop_pkg.sv
// types for the registered sum-of-products logic element
package sop_pkg;
  // ------------------------------------------------------------------
  // power-up sequencing states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SOP_ST_PWRUP,
    SOP_ST_RUN
  } sop_state_t;
endpackage : sop_pkg

// ### testbench/sop_board.sv
// board model that drives and resolves the eight shared pins
`timescale 1ns/100ps
module sop_board (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic [7:0] dev_oe_in,
  input  wire logic [7:0] drv_en_in,
  input  wire logic [7:0] drv_val_in,
  output logic      [7:0] pin_lvl_out
);
  logic [7:0] last_ff = 8'h00;
  // ------------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------------
  // a floating pin shows the inverse of its last level, so a stale copy never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe_in[i]) pin_lvl_out[i] = dev_data_in[i];
      else if (drv_en_in[i]) pin_lvl_out[i] = drv_val_in[i];
      else pin_lvl_out[i] = ~last_ff[i];
    end
  end
  // remember the level seen at each edge
  always_ff @(posedge sys_clk_in) begin
    last_ff <= pin_lvl_out;
  end
endmodule : sop_board

// ### testbench/test_sop_logic.sv
// self-checking bench for the registered sum-of-products element
`timescale 1ns/100ps
`include "sop_regs.svh"
module test_sop_logic;
  localparam int PWR = 4;
  logic        sys_clk_in, rst_in, oe_n_in, preload_in, prog_we_in, fuse_blow_in, rd_in, ready_out;
  logic [9:0]  ded_in;
  logic [7:0]  pin_in, pin_out, pin_oe_out, drv_en, drv_val;
  logic [5:0]  prog_term_in, rd_term_in;
  logic [31:0] prog_open_in, rd_data_out, rd_val;
  int          err_total, total_checks, cyc;
  // ------------------------------------------------------------------
  // device, board and clock
  // ------------------------------------------------------------------
  sop_logic #(.VARIANT(`SOP_VAR_R6), .PWRUP_CYC(PWR)) sop_logic_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .ded_in(ded_in), .oe_n_in(oe_n_in), .preload_in(preload_in), .pin_in(pin_in), .prog_we_in(prog_we_in),
    .prog_term_in(prog_term_in), .prog_open_in(prog_open_in), .fuse_blow_in(fuse_blow_in), .rd_in(rd_in),
    .rd_term_in(rd_term_in), .rd_data_out(rd_data_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .ready_out(ready_out));
  sop_board sop_board_i (.sys_clk_in(sys_clk_in), .dev_data_in(pin_out), .dev_oe_in(pin_oe_out),
    .drv_en_in(drv_en), .drv_val_in(drv_val), .pin_lvl_out(pin_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // opening a link removes that column from the term
  task automatic prog(input logic [5:0] term, input logic [31:0] open);
    @(posedge sys_clk_in);
    prog_we_in <= 1'b1;
    prog_term_in <= term;
    prog_open_in <= open;
    @(posedge sys_clk_in);
    prog_we_in <= 1'b0;
  endtask : prog
  task automatic read_term(input logic [5:0] term);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    rd_term_in <= term;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    // read data stands only in the cycle after the strobe
    #1 rd_val = rd_data_out;
  endtask : read_term
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the fewer than fifty cycles the tests need
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_in, oe_n_in, preload_in, prog_we_in, fuse_blow_in, rd_in} = 6'h20;
    {ded_in, prog_term_in, rd_term_in, prog_open_in, drv_en, drv_val} = '0;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1 check(pin_oe_out, 8'h00);
    repeat (PWR) @(posedge sys_clk_in);
    #1 check(ready_out, 1'b0);
    check(pin_oe_out, 8'h00);
    for (int i = 0; i < 4 && ready_out !== 1'b1; i++) @(posedge sys_clk_in);
    repeat (2) @(posedge sys_clk_in);
    #1 check(ready_out, 1'b1);
    check(pin_out, 8'h00);
    check(pin_oe_out, 8'h7E);
    $display("power-up test done");
    prog(6'h08, 32'hFFFFFFFE);
    prog(6'h10, 32'hFFFBFFFF);
    prog(6'h00, 32'hFFFFFFFF);
    prog(6'h01, 32'hFFFFFFFB);
    read_term(6'h08);
    check(rd_val, 32'hFFFFFFFE);
    read_term(6'h09);
    check(rd_val, 32'h00000000);
    @(posedge sys_clk_in);
    ded_in <= 10'h003;
    @(posedge sys_clk_in);
    #1 check(pin_out[2:0], 3'h3);
    check(pin_oe_out, 8'h7F);
    @(posedge sys_clk_in);
    #1 check(pin_out[2:0], 3'h7);
    $display("array test done");
    @(posedge sys_clk_in);
    oe_n_in <= 1'b1;
    ded_in <= 10'h000;
    @(posedge sys_clk_in);
    #1 check(pin_oe_out, 8'h01);
    @(posedge sys_clk_in);
    drv_en <= 8'h7E;
    drv_val <= 8'h5A;
    preload_in <= 1'b1;
    @(posedge sys_clk_in);
    preload_in <= 1'b0;
    drv_en <= 8'h00;
    oe_n_in <= 1'b0;
    #1 check(pin_out[6:1], 6'h2D);
    @(posedge sys_clk_in);
    #1 check(pin_out[2:1], 2'h2);
    check(pin_oe_out[6:1], 6'h3F);
    $display("preload test done");
    prog(6'h09, 32'hBFFFFFFF);
    @(posedge sys_clk_in);
    drv_en <= 8'h80;
    drv_val <= 8'h80;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    #1 check(pin_out[1], 1'b1);
    check(pin_oe_out[7], 1'b0);
    @(posedge sys_clk_in);
    drv_en <= 8'h00;
    fuse_blow_in <= 1'b1;
    @(posedge sys_clk_in);
    fuse_blow_in <= 1'b0;
    read_term(6'h08);
    check(rd_val, 32'h00000000);
    $display("input pin and fuse test done");
    tally_and_finish();
  end
endmodule : test_sop_logic
